// ==== ebc_pkg.sv ====
// external bus area and refresh control: shared constants and types
// assumes a 32-bit ahb-lite slave port, registers in the low byte of a word
package ebc_pkg;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_BUS_WIDTH    = 16'hfed0;
	localparam logic [15:0] IDX_ACCESS_STATE = 16'hfed1;
	localparam logic [15:0] IDX_WAIT_HIGH    = 16'hfed2;
	localparam logic [15:0] IDX_WAIT_LOW     = 16'hfed3;
	localparam logic [15:0] IDX_BUS_CTL_HIGH = 16'hfed4;
	localparam logic [15:0] IDX_BUS_CTL_LOW  = 16'hfed5;
	localparam logic [15:0] IDX_MEM_CTL      = 16'hfed6;
	localparam logic [15:0] IDX_DRAM_CTL     = 16'hfed7;
	localparam logic [15:0] IDX_RFSH_COUNT   = 16'hfed8;
	localparam logic [15:0] IDX_RFSH_PERIOD  = 16'hfed9;
	localparam logic [15:0] IDX_IRQ_STATUS   = 16'hfedc;
	localparam logic [15:0] IDX_IRQ_CLEAR    = 16'hfedd;
	localparam logic [15:0] IDX_IRQ_ENABLE   = 16'hfede;

	// reset values
	localparam logic [7:0] RST_WIDTH_MODE4   = 8'h00;
	localparam logic [7:0] RST_WIDTH_OTHER   = 8'hff;
	localparam logic [7:0] RST_ACCESS_STATE  = 8'hff;
	localparam logic [7:0] RST_WAIT          = 8'hff;
	localparam logic [7:0] RST_BUS_CTL_HIGH  = 8'h00;
	localparam logic [7:0] RST_BUS_CTL_LOW   = 8'h00;
	localparam logic [7:0] RST_MEM_CTL       = 8'h00;
	localparam logic [7:0] RST_DRAM_CTL      = 8'h00;
	localparam logic [7:0] RST_RFSH_COUNT    = 8'h00;
	localparam logic [7:0] RST_RFSH_PERIOD   = 8'hff;

	// field positions
	localparam int REFRESH_EN_BIT   = 7;
	localparam int CBR_WAIT_BIT     = 6;
	localparam int SELF_REFRESH_BIT = 5;
	localparam int MATCH_FLAG_BIT   = 4;
	localparam int MATCH_IE_BIT     = 3;
	localparam int CLK_SEL_LSB      = 0;
	localparam int IDLE_CYCLE_BIT   = 7;
	localparam int PRECHARGE_BIT    = 3;
	localparam int IRQ_MATCH_BIT    = 0;
	localparam int IRQ_REFRESH_BIT  = 1;
	localparam int IRQ_W            = 2;

	// timing
	localparam int           PRESCALE_W   = 12;
	localparam logic [1:0]   STRAP_SETTLE = 2'h2;

	// ahb-lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	typedef enum logic [1:0] {
		EBC_PH_IDLE  = 2'h1,
		EBC_PH_WRITE = 2'h2
	} ebc_phase_t;

	function automatic logic [31:0] reg_addr(input logic [15:0] idx);
		reg_addr = {14'h0, idx, 2'h0};
	endfunction : reg_addr

endpackage : ebc_pkg

// ==== ebc_prescaler.sv ====
// refresh counter clock divider: one-cycle enable at the selected rate
// assumes the select code comes from a register on the same clock
module ebc_prescaler #(
	parameter int W = ebc_pkg::PRESCALE_W
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [2:0]   clk_sel,
	output logic              tick
);

	logic [W-1:0] div;
	logic [W-1:0] mask;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div <= '0;
		end else begin
			div <= div + 1'b1;
		end
	end

	// mask of low bits that must all be ones for the chosen division
	always_comb begin
		unique case (clk_sel)
			3'h1: mask = W'(12'h001);
			3'h2: mask = W'(12'h007);
			3'h3: mask = W'(12'h01f);
			3'h4: mask = W'(12'h07f);
			3'h5: mask = W'(12'h1ff);
			3'h6: mask = W'(12'h7ff);
			default: mask = W'(12'hfff);
		endcase
	end

	// code zero stops the tick entirely; div keeps counting
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick <= 1'b0;
		end else begin
			tick <= (clk_sel != 3'h0) && ((div & mask) == mask);
		end
	end

endmodule : ebc_prescaler

// ==== ebc_ctrl.sv ====
// external bus area configuration and dram refresh timer, ahb-lite slave
// assumes one slave on the bus, zero-wait answers, word transfers only
//
// Summary of operation
// - each area's width bit selects 16-bit access when clear, 8-bit when set.
// - each area's access-state bit selects 2-state cycles when clear, 3-state when set.
// - program waits apply to an area only while it is set for 3-state access.
// - each area's 2-bit wait field asks for zero to three program waits.
// - the idle-cycle bit inserts an idle between reads of different areas.
// - the precharge bit selects a one-state or two-state precharge cycle.
// - the refresh enable bit at bit 7 gates the refresh request and its status bit; the counter and match flag run regardless.
// - counter equal to period sets the match flag; read-one then write-zero clears it.
// - the 8-bit period register is the compare value and resets to all ones.
//
// Added by the designer: register access over AHB-Lite.
module ebc_ctrl (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic              hresp,
	output logic [31:0]       hrdata,
	input  wire logic         strap_mode4,
	output logic [7:0]        area_byte_width,
	output logic [7:0]        area_three_state,
	output logic [15:0]       area_wait_states,
	output logic              idle_cycle_enable,
	output logic              precharge_two_state,
	output logic              refresh_enable,
	output logic              cbr_refresh_wait,
	output logic              self_refresh_mode,
	output logic              refresh_request,
	output logic              compare_match_irq,
	output logic              irq
);

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [7:0]             bus_width;
	logic [7:0]             access_state;
	logic [7:0]             wait_high;
	logic [7:0]             wait_low;
	logic [7:0]             bus_ctl_high;
	logic [7:0]             bus_ctl_low;
	logic [7:0]             mem_ctl;
	logic [7:0]             dram_ctl;
	logic [7:0]             rfsh_count;
	logic [7:0]             rfsh_period;
	logic [ebc_pkg::IRQ_W-1:0] irq_status;
	logic [ebc_pkg::IRQ_W-1:0] irq_enable;

	logic                   strap_meta;
	logic                   strap_sync;
	logic [1:0]             settle;
	logic                   width_loaded;

	ebc_pkg::ebc_phase_t    phase;
	logic [31:0]            wr_addr;
	logic                   take;
	logic                   wr_en;
	logic [7:0]             wdat;
	logic [31:0]            next_rdata;
	logic                   flag_armed;
	logic                   tick;
	logic                   match;
	logic                   flag_clear;
	logic [15:0]            wait_all;

	function automatic logic hit(input logic [31:0] a,
		input logic [15:0] idx);
		hit = (a == ebc_pkg::reg_addr(idx));
	endfunction : hit

	////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: address phase capture, one data phase

	assign hreadyout = 1'b1;
	assign hresp     = ebc_pkg::HRESP_OKAY;
	assign take      = hsel && hready && htrans[1];
	assign wr_en     = (phase == ebc_pkg::EBC_PH_WRITE);
	assign wdat      = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase   <= ebc_pkg::EBC_PH_IDLE;
			wr_addr <= 32'h0;
		end else begin
			unique case (phase)
				ebc_pkg::EBC_PH_IDLE: begin
					if (take && hwrite) begin
						phase   <= ebc_pkg::EBC_PH_WRITE;
						wr_addr <= haddr;
					end
				end
				ebc_pkg::EBC_PH_WRITE: begin
					if (!(take && hwrite)) begin
						phase <= ebc_pkg::EBC_PH_IDLE;
					end
					if (take && hwrite) begin
						wr_addr <= haddr;
					end
				end
			endcase
		end
	end

	// read mux; unmapped and write-only addresses read as zero
	always_comb begin
		next_rdata = 32'h0;
		if (hit(haddr, ebc_pkg::IDX_BUS_WIDTH)) begin
			next_rdata[7:0] = bus_width;
		end else if (hit(haddr, ebc_pkg::IDX_ACCESS_STATE)) begin
			next_rdata[7:0] = access_state;
		end else if (hit(haddr, ebc_pkg::IDX_WAIT_HIGH)) begin
			next_rdata[7:0] = wait_high;
		end else if (hit(haddr, ebc_pkg::IDX_WAIT_LOW)) begin
			next_rdata[7:0] = wait_low;
		end else if (hit(haddr, ebc_pkg::IDX_BUS_CTL_HIGH)) begin
			next_rdata[7:0] = bus_ctl_high;
		end else if (hit(haddr, ebc_pkg::IDX_BUS_CTL_LOW)) begin
			next_rdata[7:0] = bus_ctl_low;
		end else if (hit(haddr, ebc_pkg::IDX_MEM_CTL)) begin
			next_rdata[7:0] = mem_ctl;
		end else if (hit(haddr, ebc_pkg::IDX_DRAM_CTL)) begin
			next_rdata[7:0] = dram_ctl;
		end else if (hit(haddr, ebc_pkg::IDX_RFSH_COUNT)) begin
			next_rdata[7:0] = rfsh_count;
		end else if (hit(haddr, ebc_pkg::IDX_RFSH_PERIOD)) begin
			next_rdata[7:0] = rfsh_period;
		end else if (hit(haddr, ebc_pkg::IDX_IRQ_STATUS)) begin
			next_rdata[ebc_pkg::IRQ_W-1:0] = irq_status;
		end else if (hit(haddr, ebc_pkg::IDX_IRQ_ENABLE)) begin
			next_rdata[ebc_pkg::IRQ_W-1:0] = irq_enable;
		end
	end

	// data is sampled at the address phase so it stands for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (take && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode strap: synchronised, then caught once after reset release

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_meta <= 1'b0;
			strap_sync <= 1'b0;
			settle     <= 2'h0;
		end else begin
			strap_meta <= strap_mode4;
			strap_sync <= strap_meta;
			if (settle != ebc_pkg::STRAP_SETTLE) begin
				settle <= settle + 2'h1;
			end
		end
	end

	// a software write before the strap is caught still wins afterwards
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_width    <= ebc_pkg::RST_WIDTH_OTHER;
			width_loaded <= 1'b0;
		end else if (wr_en && hit(wr_addr, ebc_pkg::IDX_BUS_WIDTH)) begin
			bus_width    <= wdat;
			width_loaded <= 1'b1;
		end else if (!width_loaded && settle == ebc_pkg::STRAP_SETTLE) begin
			bus_width    <= strap_sync ? ebc_pkg::RST_WIDTH_MODE4
				: ebc_pkg::RST_WIDTH_OTHER;
			width_loaded <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// area configuration registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			access_state <= ebc_pkg::RST_ACCESS_STATE;
			wait_high    <= ebc_pkg::RST_WAIT;
			wait_low     <= ebc_pkg::RST_WAIT;
			bus_ctl_high <= ebc_pkg::RST_BUS_CTL_HIGH;
			bus_ctl_low  <= ebc_pkg::RST_BUS_CTL_LOW;
			mem_ctl      <= ebc_pkg::RST_MEM_CTL;
		end else if (wr_en) begin
			if (hit(wr_addr, ebc_pkg::IDX_ACCESS_STATE)) begin
				access_state <= wdat;
			end
			if (hit(wr_addr, ebc_pkg::IDX_WAIT_HIGH)) begin
				wait_high <= wdat;
			end
			if (hit(wr_addr, ebc_pkg::IDX_WAIT_LOW)) begin
				wait_low <= wdat;
			end
			if (hit(wr_addr, ebc_pkg::IDX_BUS_CTL_HIGH)) begin
				bus_ctl_high <= wdat;
			end
			if (hit(wr_addr, ebc_pkg::IDX_BUS_CTL_LOW)) begin
				bus_ctl_low <= wdat;
			end
			if (hit(wr_addr, ebc_pkg::IDX_MEM_CTL)) begin
				mem_ctl <= wdat;
			end
		end
	end

	// areas 7..4 in the high register, 3..0 in the low one
	assign wait_all = {wait_high, wait_low};

	// outputs to the bus cycle logic, registered from the fields
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			area_byte_width     <= ebc_pkg::RST_WIDTH_OTHER;
			area_three_state    <= ebc_pkg::RST_ACCESS_STATE;
			area_wait_states    <= 16'h0;
			idle_cycle_enable   <= 1'b0;
			precharge_two_state <= 1'b0;
		end else begin
			area_byte_width  <= bus_width;
			area_three_state <= access_state;
			for (int n = 0; n < 8; n++) begin
				// 2-state areas never see program waits
				area_wait_states[2*n +: 2] <= access_state[n]
					? wait_all[2*n +: 2] : 2'h0;
			end
			idle_cycle_enable <=
				bus_ctl_high[ebc_pkg::IDLE_CYCLE_BIT];
			precharge_two_state <=
				mem_ctl[ebc_pkg::PRECHARGE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// refresh timer

	ebc_prescaler #(
		.W(ebc_pkg::PRESCALE_W)
	) u_prescaler (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_sel (dram_ctl[ebc_pkg::CLK_SEL_LSB +: 3]),
		.tick    (tick)
	);

	// match on the tick that finds count equal to period; count restarts
	assign match = tick && (rfsh_count == rfsh_period);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rfsh_count <= ebc_pkg::RST_RFSH_COUNT;
		end else if (wr_en && hit(wr_addr, ebc_pkg::IDX_RFSH_COUNT)) begin
			rfsh_count <= wdat;
		end else if (match) begin
			rfsh_count <= 8'h0;
		end else if (tick) begin
			rfsh_count <= rfsh_count + 8'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rfsh_period <= ebc_pkg::RST_RFSH_PERIOD;
		end else if (wr_en && hit(wr_addr, ebc_pkg::IDX_RFSH_PERIOD)) begin
			rfsh_period <= wdat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// dram control register and its match flag

	// reading the flag as one arms the clear; any write to the register
	// uses up the arming so a stale read cannot clear a later match
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_armed <= 1'b0;
		end else if (take && !hwrite
			&& hit(haddr, ebc_pkg::IDX_DRAM_CTL)) begin
			flag_armed <= dram_ctl[ebc_pkg::MATCH_FLAG_BIT];
		end else if (wr_en && hit(wr_addr, ebc_pkg::IDX_DRAM_CTL)) begin
			flag_armed <= 1'b0;
		end
	end

	assign flag_clear = wr_en && hit(wr_addr, ebc_pkg::IDX_DRAM_CTL)
		&& flag_armed && !wdat[ebc_pkg::MATCH_FLAG_BIT];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dram_ctl <= ebc_pkg::RST_DRAM_CTL;
		end else begin
			if (wr_en && hit(wr_addr, ebc_pkg::IDX_DRAM_CTL)) begin
				dram_ctl[7:5] <= wdat[7:5];
				dram_ctl[3:0] <= wdat[3:0];
			end
			// a match in the clearing cycle keeps the flag set
			if (match) begin
				dram_ctl[ebc_pkg::MATCH_FLAG_BIT] <= 1'b1;
			end else if (flag_clear) begin
				dram_ctl[ebc_pkg::MATCH_FLAG_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			refresh_enable    <= 1'b0;
			cbr_refresh_wait  <= 1'b0;
			self_refresh_mode <= 1'b0;
			refresh_request   <= 1'b0;
			compare_match_irq <= 1'b0;
		end else begin
			refresh_enable    <= dram_ctl[ebc_pkg::REFRESH_EN_BIT];
			cbr_refresh_wait  <= dram_ctl[ebc_pkg::CBR_WAIT_BIT];
			self_refresh_mode <= dram_ctl[ebc_pkg::SELF_REFRESH_BIT];
			refresh_request   <= match
				&& dram_ctl[ebc_pkg::REFRESH_EN_BIT];
			compare_match_irq <= (match
				|| (dram_ctl[ebc_pkg::MATCH_FLAG_BIT] && !flag_clear))
				&& dram_ctl[ebc_pkg::MATCH_IE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky event status, write-one clear, enable, one level interrupt

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_enable <= '0;
		end else if (wr_en && hit(wr_addr, ebc_pkg::IDX_IRQ_ENABLE)) begin
			irq_enable <= wdat[ebc_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status <= '0;
		end else begin
			for (int b = 0; b < ebc_pkg::IRQ_W; b++) begin
				if ((b == ebc_pkg::IRQ_MATCH_BIT && match)
					|| (b == ebc_pkg::IRQ_REFRESH_BIT && match
					&& dram_ctl[ebc_pkg::REFRESH_EN_BIT])) begin
					irq_status[b] <= 1'b1;
				end else if (wr_en
					&& hit(wr_addr, ebc_pkg::IDX_IRQ_CLEAR)
					&& wdat[b]) begin
					irq_status[b] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

endmodule : ebc_ctrl

// ==== ebc_ext_mem.sv ====
// far-side model: external memories seen through the area settings
// assumes config outputs and refresh pulses come straight from ebc_ctrl
module ebc_ext_mem (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [2:0]  area_sel,
	input  wire logic [7:0]  area_byte_width,
	input  wire logic [7:0]  area_three_state,
	input  wire logic [15:0] area_wait_states,
	input  wire logic        refresh_request,
	output logic [3:0]       access_states,
	output logic [1:0]       bus_bytes,
	output logic [15:0]      refresh_count
);
	logic [1:0] waits;

	// trusts the device to zero waits of 2-state areas
	assign waits = area_wait_states[{area_sel, 1'b0} +: 2];
	assign access_states = (area_three_state[area_sel] ? 4'h3 : 4'h2)
		+ {2'h0, waits};
	assign bus_bytes = area_byte_width[area_sel] ? 2'h1 : 2'h2;

	////////////////////////////////////////
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			refresh_count <= 16'h0;
		end else if (refresh_request) begin
			refresh_count <= refresh_count + 16'h1;
		end
	end
endmodule : ebc_ext_mem

// ==== ebc_props.sv ====
// checker: bus answers and config outputs of ebc_ctrl
// assumes one slave, so hready is the slave's own hreadyout
module ebc_props (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic [7:0]  area_byte_width,
	input wire logic [7:0]  area_three_state,
	input wire logic [15:0] area_wait_states,
	input wire logic        idle_cycle_enable,
	input wire logic        precharge_two_state,
	input wire logic        refresh_enable,
	input wire logic        refresh_request
);
	localparam logic [31:0] A_AW = {14'h0, ebc_pkg::IDX_BUS_WIDTH, 2'h0};
	localparam logic [31:0] A_AS = {14'h0, ebc_pkg::IDX_ACCESS_STATE, 2'h0};
	localparam logic [31:0] A_BH = {14'h0, ebc_pkg::IDX_BUS_CTL_HIGH, 2'h0};
	localparam logic [31:0] A_MC = {14'h0, ebc_pkg::IDX_MEM_CTL, 2'h0};
	localparam logic [31:0] A_DR = {14'h0, ebc_pkg::IDX_DRAM_CTL, 2'h0};
	logic        tw;
	logic        tr;
	logic [15:0] ts2;

	assign tw = hsel && hready && htrans[1] && hwrite;
	assign tr = hsel && hready && htrans[1] && !hwrite;
	always_comb begin
		for (int n = 0; n < 8; n++) begin
			ts2[2*n +: 2] = {2{area_three_state[n]}};
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	////////////////////////////////////////
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	rdata_hold_a: assert property (!$past(tr) |-> $stable(hrdata))
		else $error("read data moved without a read");
	wait_gate_a: assert property ((area_wait_states & ~ts2) == 16'h0)
		else $error("waits on a 2-state area");
	abw_follow_a: assert property ($past(tw && haddr == A_AW, 3)
		|-> area_byte_width == $past(hwdata[7:0], 2))
		else $error("width output not the written value");
	ast_follow_a: assert property ($past(tw && haddr == A_AS, 3)
		|-> area_three_state == $past(hwdata[7:0], 2))
		else $error("state output not the written value");
	idle_follow_a: assert property ($past(tw && haddr == A_BH, 3)
		|-> idle_cycle_enable == $past(hwdata[7], 2))
		else $error("idle output not the written bit");
	prech_follow_a: assert property ($past(tw && haddr == A_MC, 3)
		|-> precharge_two_state == $past(hwdata[3], 2))
		else $error("precharge output not the written bit");
	refen_follow_a: assert property ($past(tw && haddr == A_DR, 3)
		|-> refresh_enable == $past(hwdata[7], 2))
		else $error("refresh enable not the written bit");
	rreq_pulse_a: assert property (refresh_request |=> !refresh_request)
		else $error("refresh request longer than a cycle");
	rreq_gate_a: assert property (refresh_request
		|-> refresh_enable || $past(refresh_enable))
		else $error("refresh request while disabled");
endmodule : ebc_props

bind ebc_ctrl ebc_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .area_byte_width,
	.area_three_state, .area_wait_states, .idle_cycle_enable,
	.precharge_two_state, .refresh_enable, .refresh_request);

// ==== tb_external_bus_area_and_refresh_control.sv ====
// testbench: register bus, area config, refresh timer and interrupt
// assumes zero-wait slave answers and the far-side model ebc_ext_mem
module tb_external_bus_area_and_refresh_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk, hresetn, hsel, hwrite, strap_mode4, rd_d;
	logic [31:0] haddr, hwdata, lf;
	logic [1:0]  htrans;
	logic [2:0]  hsize, asel;
	logic [7:0]  a, rv [10];
	logic [15:0] gw, rc;
	logic [31:0] expq [$];
	int          failures, checked, t, kx [8];
	wire logic        hreadyout, hresp, idle_cycle_enable, precharge_two_state;
	wire logic        refresh_enable, refresh_request, compare_match_irq, irq;
	wire logic        cbr_refresh_wait, self_refresh_mode;
	wire logic [31:0] hrdata;
	wire logic [7:0]  area_byte_width, area_three_state;
	wire logic [15:0] area_wait_states, rcnt;
	wire logic [3:0]  acc;

	ebc_ctrl uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .strap_mode4,
		.area_byte_width, .area_three_state, .area_wait_states,
		.idle_cycle_enable, .precharge_two_state, .refresh_enable,
		.cbr_refresh_wait, .self_refresh_mode, .refresh_request,
		.compare_match_irq, .irq);
	ebc_ext_mem mem (.hclk, .hresetn, .area_sel(asel), .area_byte_width,
		.area_three_state, .area_wait_states, .refresh_request,
		.access_states(acc), .bus_bytes(), .refresh_count(rcnt));

	////////////////////////////////////////
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	function automatic logic [15:0] gate(input logic [15:0] w,
		input logic [7:0] m);
		for (int n = 0; n < 8; n++) begin
			if (!m[n]) w[2*n +: 2] = 2'h0;
		end
		return w;
	endfunction : gate

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	// reads note their expected value; the monitor below compares
	task automatic xfer(input logic [15:0] idx, input logic w,
		input logic [31:0] d);
		if (!w) expq.push_back(d);
		hsel <= 1'b1;
		htrans <= ebc_pkg::HTRANS_NONSEQ;
		haddr <= {14'h0, idx, 2'h0};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		if (w) hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask : xfer

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc

	task automatic wait_rr(output int c);
		c = 0;
		do begin
			@(posedge hclk);
			c++;
		end while (refresh_request !== 1'b1 && c < 20000);
	endtask : wait_rr

	task automatic do_reset(input logic m4);
		hresetn <= 1'b0;
		hsel <= 1'b0;
		htrans <= 2'h0;
		strap_mode4 <= m4;
		cyc(2);
		hresetn <= 1'b1;
		cyc(4);
	endtask : do_reset

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		if (rd_d && expq.size() > 0) cmp(hrdata, expq.pop_front());
		rd_d = hresetn && hsel && htrans[1] && !hwrite && hreadyout;
	end

	initial begin
		#600us;
		failures++;
		give_verdict();
	end

	initial begin
		{hresetn, hsel, hwrite, strap_mode4} = 4'h0;
		{haddr, hwdata, htrans, asel} = 69'h0;
		hsize = 3'h2;
		lf = 32'hb847;
		failures = 0;
		checked = 0;
		rv = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'hff};
		kx = '{0, 1, 3, 5, 7, 9, 11, 12};
		do_reset(1'b0);
		for (int i = 0; i < 10; i++) begin
			xfer(ebc_pkg::IDX_BUS_WIDTH + 16'(i), 1'b0, 32'(rv[i]));
		end
		xfer(16'hfeda, 1'b1, 32'hff);
		xfer(16'hfeda, 1'b0, 32'h0);
		$display("test reset values done");
		for (int i = 0; i < 6; i++) begin
			lf = lfsr_next(lf);
			a = (i == 0) ? 8'h00 : lf[15:8];
			gw = gate(lf[31:16], a);
			asel <= lf[2:0];
			xfer(ebc_pkg::IDX_BUS_WIDTH, 1'b1, 32'(lf[7:0]));
			xfer(ebc_pkg::IDX_ACCESS_STATE, 1'b1, 32'(a));
			xfer(ebc_pkg::IDX_WAIT_LOW, 1'b1, 32'(lf[23:16]));
			xfer(ebc_pkg::IDX_WAIT_HIGH, 1'b1, 32'(lf[31:24]));
			xfer(ebc_pkg::IDX_BUS_CTL_HIGH, 1'b1, 32'(lf[23:16]));
			xfer(ebc_pkg::IDX_MEM_CTL, 1'b1, 32'(lf[31:24]));
			// outputs follow the registers one edge after the write lands
			cyc(2);
			cmp(32'(area_byte_width), 32'(lf[7:0]));
			cmp(32'(area_three_state), 32'(a));
			cmp(32'(area_wait_states), 32'(gw));
			cmp(32'(idle_cycle_enable), 32'(lf[23]));
			cmp(32'(precharge_two_state), 32'(lf[27]));
			cmp(32'(acc), 32'((a[asel] ? 3 : 2) + gw[{asel, 1'b0} +: 2]));
			xfer(ebc_pkg::IDX_WAIT_LOW, 1'b0, 32'(lf[23:16]));
		end
		$display("test area config done");
		xfer(ebc_pkg::IDX_RFSH_PERIOD, 1'b1, 32'h1);
		for (int s = 1; s < 8; s++) begin
			xfer(ebc_pkg::IDX_DRAM_CTL, 1'b1, 32'h80 | 32'(s));
			// the first pulse may still come from the old rate
			wait_rr(t);
			wait_rr(t);
			wait_rr(t);
			cmp(32'(t), 32'(2 << kx[s]));
		end
		xfer(ebc_pkg::IDX_DRAM_CTL, 1'b1, 32'h01);
		cyc(2);
		rc = rcnt;
		cyc(40);
		cmp(32'(rcnt), 32'(rc));
		$display("test refresh timer done");
		xfer(ebc_pkg::IDX_IRQ_ENABLE, 1'b1, 32'h0);
		xfer(ebc_pkg::IDX_RFSH_PERIOD, 1'b1, 32'h0);
		xfer(ebc_pkg::IDX_RFSH_COUNT, 1'b1, 32'h0);
		xfer(ebc_pkg::IDX_DRAM_CTL, 1'b1, 32'h89);
		cyc(8);
		// stop the counter first so no fresh match hides a bad clear
		xfer(ebc_pkg::IDX_DRAM_CTL, 1'b1, 32'h08);
		cyc(2);
		// a zero to the flag without a prior read of one must not clear it
		xfer(ebc_pkg::IDX_DRAM_CTL, 1'b1, 32'h08);
		cyc(2);
		cmp(32'(compare_match_irq), 32'h1);
		xfer(ebc_pkg::IDX_IRQ_STATUS, 1'b0, 32'h3);
		cmp(32'(irq), 32'h0);
		xfer(ebc_pkg::IDX_IRQ_ENABLE, 1'b1, 32'h1);
		cyc(2);
		cmp(32'(irq), 32'h1);
		xfer(ebc_pkg::IDX_IRQ_CLEAR, 1'b1, 32'h3);
		cyc(2);
		cmp(32'(irq), 32'h0);
		xfer(ebc_pkg::IDX_IRQ_STATUS, 1'b0, 32'h0);
		xfer(ebc_pkg::IDX_DRAM_CTL, 1'b0, 32'h18);
		xfer(ebc_pkg::IDX_DRAM_CTL, 1'b1, 32'h08);
		cyc(1);
		cmp(32'(compare_match_irq), 32'h0);
		xfer(ebc_pkg::IDX_DRAM_CTL, 1'b1, 32'h78);
		xfer(ebc_pkg::IDX_DRAM_CTL, 1'b0, 32'h68);
		cmp(32'({cbr_refresh_wait, self_refresh_mode}), 32'h3);
		xfer(ebc_pkg::IDX_RFSH_COUNT, 1'b1, 32'h5a);
		cyc(20);
		xfer(ebc_pkg::IDX_RFSH_COUNT, 1'b0, 32'h5a);
		$display("test match flag done");
		do_reset(1'b1);
		xfer(ebc_pkg::IDX_BUS_WIDTH, 1'b0, 32'h0);
		cmp(32'(area_byte_width), 32'h0);
		$display("test mode strap done");
		give_verdict();
	end
endmodule : tb_external_bus_area_and_refresh_control
